/* hdl/ncr_pkg.sv */
// Package with the address map, reset values and timing of the common registers
package ncr_pkg;
  localparam logic [23:0] GATEWAY_ADDR_LO = 24'hfe0001;
  localparam logic [23:0] SUBNET_MASK_LO = 24'hfe0005;
  localparam logic [23:0] LOCAL_HW_LO = 24'hfe0009;
  localparam logic [23:0] LOCAL_IP_LO = 24'hfe000f;
  localparam logic [23:0] COMMON_FLAGS_ADDR = 24'hfe0015;
  localparam logic [23:0] SOCKET_MASK_ADDR = 24'hfe0016;
  localparam logic [23:0] RETRY_PERIOD_LO = 24'hfe0017;
  localparam logic [23:0] RETRY_COUNT_ADDR = 24'hfe0019;
  localparam logic [23:0] PPP_AUTH_LO = 24'hfe001c;
  localparam logic [23:0] SUMMARY_ADDR = 24'hfe0034;

  localparam int CONFLICT_BIT = 7;
  localparam int DEST_LOST_BIT = 6;
  localparam int LINK_CLOSED_BIT = 5;

  localparam logic [31:0] ADDR4_RESET = 32'h0000_0000;
  localparam logic [47:0] HW_RESET = 48'h0000_0000_0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] RETRY_PERIOD_RESET = 16'h07d0;
  localparam logic [7:0] RETRY_COUNT_RESET = 8'h08;
  localparam logic [15:0] PPP_AUTH_RESET = 16'h0000;
  localparam logic [15:0] AUTH_PAP = 16'hc023;
  localparam logic [15:0] AUTH_CHAP = 16'hc223;

  localparam int CLK_FREQ_KHZ = 20000;
  localparam int RETRY_UNIT_US = 100;
  localparam int RETRY_UNIT_CYCLES = (RETRY_UNIT_US * CLK_FREQ_KHZ) / 1000;
  localparam logic [16:0] WAIT_LIMIT = 17'h0ffff;

  typedef enum logic [1:0] {
    NCR_IDLE = 2'b01,
    NCR_WAIT = 2'b10
  } ncr_state_t;

  typedef struct packed {
    logic [23:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ncr_bus_t;

  typedef struct packed {
    logic start;
    logic is_tcp;
    logic [2:0] sock;
    logic answered;
  } ncr_retry_req_t;

  typedef struct packed {
    logic retransmit;
    logic [2:0] sock;
    logic [7:0] timeout_flag;
    logic [7:0] close_socket;
  } ncr_retry_out_t;

  typedef struct packed {
    logic [31:0] gateway;
    logic [31:0] subnet;
    logic [47:0] hw;
    logic [31:0] ip;
    logic [7:0] flags;
    logic [7:0] smask;
    logic [15:0] period;
    logic [7:0] count;
    logic [15:0] auth;
    logic [7:0] summary;
    logic [7:0] rdata;
    logic irq_n;
    ncr_state_t state;
    logic [10:0] tick_cnt;
    logic tick;
    logic [15:0] wait_units;
    logic [15:0] remain;
    logic [7:0] attempts;
    logic is_tcp;
    ncr_retry_out_t rout;
  } ncr_state_s_t;
endpackage

/* hdl/ncr_regs.sv */
// Common register bank of the network engine with its retry timer
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps
// What this block does
// - Four-byte gateway address at fe0001-fe0004, zero after reset.
// - Four-byte subnet mask at fe0005-fe0008, zero after reset.
// - Six-byte local hardware address at fe0009-fe000e, zero after reset.
// - Four-byte local IP address at fe000f-fe0012, zero after reset.
// - Interrupt line low while any common flag or unmasked summary bit set, high when all clear.
// - Bit 7 set on ARP request matching local IP; write one clears.
// - Bit 6 set on ICMP unreachable during UDP send; write one clears.
// - Bit 5 set on PPPoE close in PPPoE mode; bits 4-0 reserved.
// - Socket mask at fe0016, zero after reset; set bit lets socket interrupt.
// - Cleared mask bit blocks that socket's interrupt even when flagged.
// - Sixteen-bit retry period at fe0017, 100 us units, resets to 07d0.
// - Retransmit pending packet when no answer comes within the period.
// - Retry count at fe0019 resets to 08; exceeding it flags timeout.
// - TCP final timeout closes the socket in the same cycle as flag.
// - ARP: fixed period per wait, count-plus-one waits, then final timeout.
// - TCP segments retried count times, then close and flag.
// - TCP wait doubles per attempt, held once doubling would pass 65535.
// - Read-only auth type at fe001c, zero after reset, c023 or c223.
// - Summary bit set on socket interrupt, cleared when socket flags zero.
module ncr_regs (
  input wire logic core_clk, // 20 MHz clock
  input wire logic sys_rst, // Synchronous reset, active high
  input wire ncr_pkg::ncr_bus_t bus, // Byte register access
  output logic [7:0] rdata, // Read data, cycle after the read strobe
  input wire logic arp_req_seen, // ARP request received, pulse
  input wire logic [31:0] arp_target_ip, // IP carried by that request
  input wire logic dest_lost_evt, // ICMP unreachable during UDP send
  input wire logic ppp_mode, // PPPoE mode active
  input wire logic ppp_close_evt, // PPPoE session closed
  input wire logic auth_load, // Load negotiated auth type
  input wire logic [15:0] auth_value, // Negotiated auth type
  input wire logic [7:0] socket_irq_evt, // Socket raised an interrupt
  input wire logic [7:0] socket_flags_nz, // Socket flag register nonzero
  input wire ncr_pkg::ncr_retry_req_t rreq, // Pending packet control
  output ncr_pkg::ncr_retry_out_t rout, // Retransmit and timeout pulses
  output logic [31:0] local_ip_address, // Local IP for the engine
  output logic [47:0] local_hw_address, // Local MAC for the engine
  output logic [31:0] gateway_address, // Gateway for the engine
  output logic [31:0] subnet_mask, // Subnet for the engine
  output logic net_engine_irq_n // Interrupt line, active low
);

  ncr_pkg::ncr_state_s_t q;
  ncr_pkg::ncr_state_s_t d;

  ////////////////////////////////////////////////////////////////////////////
  // Byte helpers

  function automatic logic [7:0] pick_byte(input logic [47:0] val, input int nbytes,
                                           input logic [23:0] offset);
    int sh;
    sh = (nbytes - 1 - int'(offset)) * 8;
    pick_byte = val[sh +: 8];
  endfunction

  function automatic logic in_range(input logic [23:0] a, input logic [23:0] lo,
                                    input int nbytes);
    in_range = (a >= lo) && (a < lo + 24'(nbytes));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic arp_hit;
  logic [16:0] doubled;
  logic flags_wr;
  logic [7:0] sock_onehot;

  always_comb begin
    d = q;
    arp_hit = arp_req_seen && (arp_target_ip == q.ip);
    doubled = {q.wait_units, 1'b0};
    flags_wr = bus.wr && (bus.addr == ncr_pkg::COMMON_FLAGS_ADDR);
    sock_onehot = 8'h01 << q.rout.sock;
    d.rdata = ncr_pkg::BYTE_RESET;
    d.rout.retransmit = 1'b0;
    d.rout.timeout_flag = 8'h00;
    d.rout.close_socket = 8'h00;

    // Register writes, one byte per cycle
    if (bus.wr) begin
      if (in_range(bus.addr, ncr_pkg::GATEWAY_ADDR_LO, 4)) begin
        d.gateway[(3 - int'(bus.addr - ncr_pkg::GATEWAY_ADDR_LO)) * 8 +: 8] = bus.wdata;
      end else if (in_range(bus.addr, ncr_pkg::SUBNET_MASK_LO, 4)) begin
        d.subnet[(3 - int'(bus.addr - ncr_pkg::SUBNET_MASK_LO)) * 8 +: 8] = bus.wdata;
      end else if (in_range(bus.addr, ncr_pkg::LOCAL_HW_LO, 6)) begin
        d.hw[(5 - int'(bus.addr - ncr_pkg::LOCAL_HW_LO)) * 8 +: 8] = bus.wdata;
      end else if (in_range(bus.addr, ncr_pkg::LOCAL_IP_LO, 4)) begin
        d.ip[(3 - int'(bus.addr - ncr_pkg::LOCAL_IP_LO)) * 8 +: 8] = bus.wdata;
      end else if (bus.addr == ncr_pkg::SOCKET_MASK_ADDR) begin
        d.smask = bus.wdata;
      end else if (in_range(bus.addr, ncr_pkg::RETRY_PERIOD_LO, 2)) begin
        d.period[(1 - int'(bus.addr - ncr_pkg::RETRY_PERIOD_LO)) * 8 +: 8] = bus.wdata;
      end else if (bus.addr == ncr_pkg::RETRY_COUNT_ADDR) begin
        d.count = bus.wdata;
      end
    end

    // Register reads, unmapped bytes read zero
    if (bus.rd) begin
      if (in_range(bus.addr, ncr_pkg::GATEWAY_ADDR_LO, 4)) begin
        d.rdata = pick_byte({16'h0000, q.gateway}, 4, bus.addr - ncr_pkg::GATEWAY_ADDR_LO);
      end else if (in_range(bus.addr, ncr_pkg::SUBNET_MASK_LO, 4)) begin
        d.rdata = pick_byte({16'h0000, q.subnet}, 4, bus.addr - ncr_pkg::SUBNET_MASK_LO);
      end else if (in_range(bus.addr, ncr_pkg::LOCAL_HW_LO, 6)) begin
        d.rdata = pick_byte(q.hw, 6, bus.addr - ncr_pkg::LOCAL_HW_LO);
      end else if (in_range(bus.addr, ncr_pkg::LOCAL_IP_LO, 4)) begin
        d.rdata = pick_byte({16'h0000, q.ip}, 4, bus.addr - ncr_pkg::LOCAL_IP_LO);
      end else if (bus.addr == ncr_pkg::COMMON_FLAGS_ADDR) begin
        d.rdata = q.flags;
      end else if (bus.addr == ncr_pkg::SOCKET_MASK_ADDR) begin
        d.rdata = q.smask;
      end else if (in_range(bus.addr, ncr_pkg::RETRY_PERIOD_LO, 2)) begin
        d.rdata = pick_byte({32'h0, q.period}, 2, bus.addr - ncr_pkg::RETRY_PERIOD_LO);
      end else if (bus.addr == ncr_pkg::RETRY_COUNT_ADDR) begin
        d.rdata = q.count;
      end else if (in_range(bus.addr, ncr_pkg::PPP_AUTH_LO, 2)) begin
        d.rdata = pick_byte({32'h0, q.auth}, 2, bus.addr - ncr_pkg::PPP_AUTH_LO);
      end else if (bus.addr == ncr_pkg::SUMMARY_ADDR) begin
        d.rdata = q.summary;
      end
    end

    // Auth type is loaded by the engine only
    if (auth_load) begin
      d.auth = auth_value;
    end

    // Common flags: write one clears, a new event wins over the clear
    for (int b = 0; b < 8; b++) begin
      if (flags_wr && bus.wdata[b]) begin
        d.flags[b] = 1'b0;
      end
    end
    if (arp_hit) begin
      d.flags[ncr_pkg::CONFLICT_BIT] = 1'b1;
    end
    if (dest_lost_evt) begin
      d.flags[ncr_pkg::DEST_LOST_BIT] = 1'b1;
    end
    if (ppp_close_evt && ppp_mode) begin
      d.flags[ncr_pkg::LINK_CLOSED_BIT] = 1'b1;
    end
    d.flags[4:0] = 5'h00;

    // Unit tick of 100 us
    d.tick = 1'b0;
    if (q.tick_cnt == 11'(ncr_pkg::RETRY_UNIT_CYCLES - 1)) begin
      d.tick_cnt = 11'h000;
      d.tick = 1'b1;
    end else begin
      d.tick_cnt = q.tick_cnt + 11'h001;
    end

    // Retry timer
    case (q.state)
      ncr_pkg::NCR_IDLE: begin
        if (rreq.start) begin
          d.state = ncr_pkg::NCR_WAIT;
          d.wait_units = q.period;
          d.remain = q.period;
          d.attempts = 8'h00;
          d.is_tcp = rreq.is_tcp;
          d.rout.sock = rreq.sock;
        end
      end
      ncr_pkg::NCR_WAIT: begin
        if (rreq.answered) begin
          d.state = ncr_pkg::NCR_IDLE;
        end else if (q.tick && q.remain <= 16'h0001) begin
          if (q.attempts == q.count) begin
            d.state = ncr_pkg::NCR_IDLE;
            d.rout.timeout_flag = sock_onehot;
            if (q.is_tcp) begin
              d.rout.close_socket = sock_onehot;
            end
          end else begin
            d.rout.retransmit = 1'b1;
            d.attempts = q.attempts + 8'h01;
            if (q.is_tcp && doubled <= ncr_pkg::WAIT_LIMIT) begin
              d.wait_units = doubled[15:0];
            end
            d.remain = d.wait_units;
          end
        end else if (q.tick) begin
          d.remain = q.remain - 16'h0001;
        end
      end
      default: begin
        d.state = ncr_pkg::NCR_IDLE;
      end
    endcase

    // Socket summary: set wins, cleared once that socket's flags are zero
    d.summary = (q.summary & socket_flags_nz) | socket_irq_evt | d.rout.timeout_flag;

    // Interrupt line from next values, so it changes with the flags
    d.irq_n = !((|d.flags) || (|(d.summary & d.smask)));
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      q.gateway <= ncr_pkg::ADDR4_RESET;
      q.subnet <= ncr_pkg::ADDR4_RESET;
      q.hw <= ncr_pkg::HW_RESET;
      q.ip <= ncr_pkg::ADDR4_RESET;
      q.flags <= ncr_pkg::BYTE_RESET;
      q.smask <= ncr_pkg::BYTE_RESET;
      q.period <= ncr_pkg::RETRY_PERIOD_RESET;
      q.count <= ncr_pkg::RETRY_COUNT_RESET;
      q.auth <= ncr_pkg::PPP_AUTH_RESET;
      q.summary <= ncr_pkg::BYTE_RESET;
      q.rdata <= ncr_pkg::BYTE_RESET;
      q.irq_n <= 1'b1;
      q.state <= ncr_pkg::NCR_IDLE;
      q.tick_cnt <= 11'h000;
      q.tick <= 1'b0;
      q.wait_units <= 16'h0000;
      q.remain <= 16'h0000;
      q.attempts <= 8'h00;
      q.is_tcp <= 1'b0;
      q.rout <= '0;
    end else begin
      q <= d;
    end
  end

  assign rdata = q.rdata;
  assign rout = q.rout;
  assign local_ip_address = q.ip;
  assign local_hw_address = q.hw;
  assign gateway_address = q.gateway;
  assign subnet_mask = q.subnet;
  assign net_engine_irq_n = q.irq_n;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  irq_follows_flags_a: assert property ((|q.flags) |-> !net_engine_irq_n)
    else $error("Interrupt line high while a common flag is set");

  mask_blocks_a: assert property (
    (q.flags == 8'h00 && (q.summary & q.smask) == 8'h00) |-> net_engine_irq_n)
    else $error("Interrupt raised for a masked socket");

  conflict_set_a: assert property (arp_hit |=> q.flags[7])
    else $error("Address conflict not flagged");

  w1c_clear_a: assert property (
    (flags_wr && bus.wdata[6] && !dest_lost_evt) |=> !q.flags[6])
    else $error("Unreachable flag not cleared by write one");

  reserved_zero_a: assert property (q.flags[4:0] == 5'h00)
    else $error("Reserved flag bits set");

  gateway_read_a: assert property (
    (bus.rd && bus.addr == ncr_pkg::GATEWAY_ADDR_LO) |=> rdata == $past(q.gateway[31:24]))
    else $error("Gateway high byte read wrong");

  tick_spacing_a: assert property (q.tick |=> !q.tick [*8])
    else $error("Unit tick too frequent");

  tcp_close_a: assert property (
    (|rout.timeout_flag && q.is_tcp) |-> rout.close_socket == rout.timeout_flag)
    else $error("TCP socket not closed with timeout");

  no_close_udp_a: assert property ((|rout.close_socket) |-> q.is_tcp)
    else $error("Non-TCP socket closed");

  doubling_a: assert property (
    (rout.retransmit && q.is_tcp) |->
      (q.wait_units == (({1'b0, $past(q.wait_units), 1'b0} <= 18'h0ffff) ?
        16'($past(q.wait_units) << 1) : $past(q.wait_units))))
    else $error("Wait not doubled or held correctly");

  arp_fixed_a: assert property ((rout.retransmit && !q.is_tcp) |->
    q.wait_units == $past(q.wait_units))
    else $error("ARP wait changed between attempts");

  auth_ro_a: assert property (
    (bus.wr && !auth_load) |=> q.auth == $past(q.auth))
    else $error("Auth type changed by a write");

  summary_clear_a: assert property (
    (socket_flags_nz == 8'h00 && socket_irq_evt == 8'h00 && d.rout.timeout_flag == 8'h00)
      |=> q.summary == 8'h00)
    else $error("Summary not cleared with socket flags");

endmodule

/* verif/ncr_mcu.sv */
// Core-side bus master model issuing single-byte register cycles
`timescale 1ns/100ps
module ncr_mcu (
  input wire logic core_clk, // Bank clock
  output ncr_pkg::ncr_bus_t bus, // Byte access to the bank
  input wire logic [7:0] rdata // Read data from the bank
);
  initial begin
    bus = '0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // One-byte write; idle lines get the inverse so stale values never match
  task automatic wr(input logic [23:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask
  // One-byte read; data taken in the single cycle it stands
  task automatic rd(input logic [23:0] a, output logic [7:0] d);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: 8'h5a, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus <= '{addr: ~a, wdata: 8'ha5, wr: 1'b0, rd: 1'b0};
    #1;
    d = rdata;
  endtask
endmodule

/* verif/ncr_regs_test.sv */
// Self-checking bench for the common register bank
`timescale 1ns/100ps
module ncr_regs_test;
  logic core_clk, sys_rst, arp_req_seen, dest_lost_evt, ppp_mode, ppp_close_evt, auth_load;
  logic [31:0] arp_target_ip, local_ip_address, gateway_address, subnet_mask;
  logic [15:0] auth_value;
  logic [7:0] socket_irq_evt, socket_flags_nz, rdata;
  logic [47:0] local_hw_address;
  logic net_engine_irq_n;
  ncr_pkg::ncr_bus_t bus;
  ncr_pkg::ncr_retry_req_t rreq;
  ncr_pkg::ncr_retry_out_t rout;
  int failures, n_tests;

  ncr_regs u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .bus(bus), .rdata(rdata),
    .arp_req_seen(arp_req_seen), .arp_target_ip(arp_target_ip), .dest_lost_evt(dest_lost_evt),
    .ppp_mode(ppp_mode), .ppp_close_evt(ppp_close_evt), .auth_load(auth_load),
    .auth_value(auth_value), .socket_irq_evt(socket_irq_evt), .socket_flags_nz(socket_flags_nz),
    .rreq(rreq), .rout(rout), .local_ip_address(local_ip_address),
    .local_hw_address(local_hw_address), .gateway_address(gateway_address),
    .subnet_mask(subnet_mask), .net_engine_irq_n(net_engine_irq_n));
  ncr_mcu u_mcu (.core_clk(core_clk), .bus(bus), .rdata(rdata));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (failures == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [23:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_mcu.rd(a, d);
    chk(d, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] e;
    for (int i = 1; i <= 8'h1d; i++) begin
      e = (i == 8'h17) ? 8'h07 : (i == 8'h18) ? 8'hd0 : (i == 8'h19) ? 8'h08 : 8'h00;
      rdchk(24'hfe0000 + 24'(i), e);
    end
    chk(net_engine_irq_n, 1'b1);
  endtask
  task automatic t_rw();
    for (int i = 0; i < 18; i++) u_mcu.wr(24'hfe0001 + 24'(i), 8'h10 + 8'(i));
    #1;
    chk(gateway_address, 32'h10111213);
    chk(subnet_mask, 32'h14151617);
    chk(local_hw_address, 48'h18191a1b1c1d);
    chk(local_ip_address, 32'h1e1f2021);
    for (int i = 0; i < 18; i++) rdchk(24'hfe0001 + 24'(i), 8'h10 + 8'(i));
    u_mcu.wr(24'hfe001c, 8'h55);
    rdchk(24'hfe001c, 8'h00);
    @(posedge core_clk) auth_load <= 1'b1;
    auth_value <= ncr_pkg::AUTH_PAP;
    @(posedge core_clk) auth_load <= 1'b0;
    rdchk(24'hfe001c, 8'hc0);
    rdchk(24'hfe001d, 8'h23);
    @(posedge core_clk) auth_load <= 1'b1;
    auth_value <= ncr_pkg::AUTH_CHAP;
    @(posedge core_clk) auth_load <= 1'b0;
    rdchk(24'hfe001c, 8'hc2);
  endtask
  task automatic t_flags();
    @(posedge core_clk) arp_req_seen <= 1'b1;
    arp_target_ip <= 32'h1e1f2022;
    @(posedge core_clk) arp_req_seen <= 1'b0;
    rdchk(24'hfe0015, 8'h00);
    @(posedge core_clk) arp_req_seen <= 1'b1;
    arp_target_ip <= 32'h1e1f2021;
    @(posedge core_clk) arp_req_seen <= 1'b0;
    tick(1);
    chk(net_engine_irq_n, 1'b0);
    @(posedge core_clk) dest_lost_evt <= 1'b1;
    @(posedge core_clk) dest_lost_evt <= 1'b0;
    rdchk(24'hfe0015, 8'hc0);
    u_mcu.wr(24'hfe0015, 8'h80);
    rdchk(24'hfe0015, 8'h40);
    chk(net_engine_irq_n, 1'b0);
    u_mcu.wr(24'hfe0015, 8'h40);
    rdchk(24'hfe0015, 8'h00);
    chk(net_engine_irq_n, 1'b1);
    @(posedge core_clk) ppp_close_evt <= 1'b1;
    @(posedge core_clk) ppp_close_evt <= 1'b0;
    rdchk(24'hfe0015, 8'h00);
    @(posedge core_clk) ppp_mode <= 1'b1;
    ppp_close_evt <= 1'b1;
    @(posedge core_clk) ppp_close_evt <= 1'b0;
    rdchk(24'hfe0015, 8'h20);
    u_mcu.wr(24'hfe0015, 8'hff);
    rdchk(24'hfe0015, 8'h00);
  endtask
  task automatic t_mask();
    @(posedge core_clk) socket_irq_evt <= 8'h04;
    socket_flags_nz <= 8'h04;
    @(posedge core_clk) socket_irq_evt <= 8'h00;
    rdchk(24'hfe0034, 8'h04);
    chk(net_engine_irq_n, 1'b1);
    u_mcu.wr(24'hfe0016, 8'h04);
    rdchk(24'hfe0016, 8'h04);
    chk(net_engine_irq_n, 1'b0);
    @(posedge core_clk) socket_flags_nz <= 8'h00;
    rdchk(24'hfe0034, 8'h00);
    chk(net_engine_irq_n, 1'b1);
    u_mcu.wr(24'hfe0016, 8'h00);
  endtask
  // Reset in mid-run drops written values and a pending flag
  task automatic t_midrst();
    @(posedge core_clk) dest_lost_evt <= 1'b1;
    @(posedge core_clk) dest_lost_evt <= 1'b0;
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    tick(1);
    chk(gateway_address, 32'h0);
    chk(subnet_mask, 32'h0);
    chk(local_hw_address, 48'h0);
    chk(local_ip_address, 32'h0);
    chk(net_engine_irq_n, 1'b1);
    rdchk(24'hfe0015, 8'h00);
    rdchk(24'hfe0017, 8'h07);
  endtask
  // Runs one pending packet to final timeout with period of one unit
  task automatic t_retry(input logic tcp, input logic [2:0] s, input logic [7:0] cnt,
                         input int lo, input int hi);
    int nret, gap;
    nret = 0;
    gap = 0;
    u_mcu.wr(24'hfe0017, 8'h00);
    u_mcu.wr(24'hfe0018, 8'h01);
    u_mcu.wr(24'hfe0019, cnt);
    rdchk(24'hfe0018, 8'h01);
    @(posedge core_clk) rreq <= '{start: 1'b1, is_tcp: tcp, sock: s, answered: 1'b0};
    @(posedge core_clk) rreq.start <= 1'b0;
    for (int k = 0; k < 40000 && rout.timeout_flag === 8'h00; k++) begin
      tick(1);
      gap++;
      if (rout.retransmit === 1'b1) begin
        nret++;
        gap = 0;
      end
    end
    chk(nret, 32'(cnt));
    chk(rout.timeout_flag, 8'h01 << s);
    chk(rout.sock, s);
    chk(rout.close_socket, tcp ? (8'h01 << s) : 8'h00);
    chk(gap >= lo && gap <= hi, 1'b1);
  endtask
  task automatic t_answer();
    logic seen;
    seen = 1'b0;
    @(posedge core_clk) rreq <= '{start: 1'b1, is_tcp: 1'b0, sock: 3'h1, answered: 1'b0};
    @(posedge core_clk) rreq.start <= 1'b0;
    tick(10);
    @(posedge core_clk) rreq.answered <= 1'b1;
    @(posedge core_clk) rreq.answered <= 1'b0;
    repeat (6000) begin
      tick(1);
      if (rout.retransmit !== 1'b0 || rout.timeout_flag !== 8'h00) seen = 1'b1;
    end
    chk(seen, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #3_000_000;
    failures++;
    conclude();
  end
  initial begin
    failures = 0;
    n_tests = 0;
    sys_rst = 1'b1;
    {arp_req_seen, dest_lost_evt, ppp_mode, ppp_close_evt, auth_load} = '0;
    arp_target_ip = '0;
    auth_value = '0;
    socket_irq_evt = '0;
    socket_flags_nz = '0;
    rreq = '0;
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_rw();
    t_flags();
    t_mask();
    t_midrst();
    t_retry(1'b0, 3'h5, 8'h02, 1, 2002);
    t_retry(1'b1, 3'h3, 8'h02, 6001, 8002);
    t_answer();
    conclude();
  end
endmodule
